/* File: qcm_counter.sv */
// Functional notes
// RL1 - Count is held in a 32-bit register covering the full range.
// RL2 - Limits span the full signed range and are rewritable while counting.
// RL3 - On limit violation counting continues or the gate closes, by configuration.
// RL4 - Violation reloads start value or opposite limit, by configuration.
// RL5 - Start value is a software register changeable at runtime.
// RL6 - Start value loads on sync, capture, violation or gate opening when enabled.
// RL7 - Pulses count only while software gate and enabled hardware gate are open.
// RL8 - Capture copies count on input edge or zero-track rising edge.
// RL9 - After capture counting continues from count or from start value.
// RL10 - Hysteresis band keeps the compare output from switching again.
// RL11 - Compare output switches at count values without software involvement.
// RL12 - Frequency and period results are reported as floating point.
// RL13 - Velocity result is reported per update interval, scaled by software.
// RL14 - Both measured value and count are readable by software.
// RL15 - Measured value refreshes at a configurable update time.
// RL16 - Update interval runs free and ignores gate opening.
// RL17 - After gate closes the last measured value stays.
// RL18 - Frequency and period ranges are covered by counter widths.
// RL19 - Measured values are signed; negative means counting down.
// RL20 - Quadrature, pulse with direction, pulse only and up/down inputs decode.
// RL21 - Direction comes from the encoder or from software.
// RL22 - Two auxiliary inputs assign to sync, capture or hardware gate.
// RL23 - Fourfold quadrature counts every edge; direction from track phase.
// RL24 - Count and limits compare as signed two's complement.
`include "qcm_defs.svh"
module qcm_counter (
  // Clock, reset and enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Encoder and auxiliary pins.
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_n,
  input wire logic [1:0] counter_aux_input,
  // Compare output.
  output logic cmp_out
);
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    qcm_pkg::qcm_ctrl_t ctrl;
    logic signed [31:0] count;
    logic signed [31:0] hi;
    logic signed [31:0] lo;
    logic signed [31:0] start;
    logic signed [31:0] capt;
    logic signed [31:0] cmp;
    logic [31:0] hyst;
    logic [31:0] upd;
    logic cmp_out;
    logic gate_q;
    logic [31:0] rdata;
  } qcm_cnt_t;
  qcm_cnt_t s;
  qcm_cnt_t next_s;
  qcm_step_if sif ();
  logic [4:0] rise;
  logic [4:0] fall;
  logic [1:0] gate_m;
  logic [1:0] capt_m;
  logic [1:0] sync_m;
  logic hw_lvl;
  logic gate;
  logic gate_open;
  logic capt_ev;
  logic sync_ev;
  logic wr;
  logic rd_setup;
  logic mapped;
  logic at_hi;
  logic at_lo;
  logic viol;
  logic plain;

  // Mask of the auxiliary inputs assigned to one function.
  function automatic logic [1:0] qcm_aux(input qcm_pkg::qcm_ctrl_t c, input qcm_pkg::qcm_fn_t f);
    qcm_aux = {c.aux1_fn == f, c.aux0_fn == f};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin edges and gate.

  // Bits: 0 a, 1 b, 2 zero track, 4:3 auxiliary inputs. Only s2 and s3 are read.
  assign rise = s.s2 & ~s.s3;
  assign fall = ~s.s2 & s.s3;
  assign gate_m = qcm_aux(s.ctrl, qcm_pkg::QCM_FN_GATE);
  assign capt_m = qcm_aux(s.ctrl, qcm_pkg::QCM_FN_CAPT);
  assign sync_m = qcm_aux(s.ctrl, qcm_pkg::QCM_FN_SYNC);
  assign hw_lvl = |(s.s2[4:3] & gate_m);
  assign gate = s.ctrl.sw_gate & (~s.ctrl.hw_gate_en | hw_lvl); // RL7 RL22
  assign gate_open = gate & ~s.gate_q;
  assign sync_ev = |(rise[4:3] & sync_m); // RL22

  always_comb
  begin
    unique case (s.ctrl.cap_src)
      qcm_pkg::QCM_C_RISE: capt_ev = |(rise[4:3] & capt_m); // RL8
      qcm_pkg::QCM_C_FALL: capt_ev = |(fall[4:3] & capt_m); // RL8
      qcm_pkg::QCM_C_BOTH: capt_ev = |((rise[4:3] | fall[4:3]) & capt_m); // RL8
      qcm_pkg::QCM_C_ZERO: capt_ev = rise[2]; // RL8
    endcase
  end

  assign sif.gate = gate;
  assign sif.up = s.ctrl.sw_dir_en ? s.ctrl.sw_dir : sif.enc_up; // RL21
  assign at_hi = s.count >= s.hi; // RL24
  assign at_lo = s.count <= s.lo; // RL24
  assign viol = sif.step & gate & (sif.up ? at_hi : at_lo);

  ////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, read data registered in the setup cycle.

  assign wr = ce & psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = s.rdata;
  assign cmp_out = s.cmp_out;

  always_comb
  begin
    mapped = 1'b1;
    unique case (paddr)
      `QCM_A_CTRL, `QCM_A_COUNT, `QCM_A_HI, `QCM_A_LO, `QCM_A_START, `QCM_A_CAPT,
      `QCM_A_CMP, `QCM_A_HYST, `QCM_A_UPD, `QCM_A_MEAS, `QCM_A_STAT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb
  begin
    next_s = s;
    next_s.s1 = {counter_aux_input, enc_n, enc_b, enc_a};
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.gate_q = gate;
    if (rd_setup)
    begin
      unique case (paddr)
        `QCM_A_CTRL: next_s.rdata = s.ctrl;
        `QCM_A_COUNT: next_s.rdata = s.count; // RL14
        `QCM_A_HI: next_s.rdata = s.hi;
        `QCM_A_LO: next_s.rdata = s.lo;
        `QCM_A_START: next_s.rdata = s.start;
        `QCM_A_CAPT: next_s.rdata = s.capt;
        `QCM_A_CMP: next_s.rdata = s.cmp;
        `QCM_A_HYST: next_s.rdata = s.hyst;
        `QCM_A_UPD: next_s.rdata = s.upd;
        `QCM_A_MEAS: next_s.rdata = sif.meas; // RL14
        `QCM_A_STAT: next_s.rdata = {28'h0, s.cmp_out, sif.up, hw_lvl, gate};
        default: next_s.rdata = `QCM_ZERO;
      endcase
    end
    if (wr)
    begin
      unique case (paddr)
        `QCM_A_CTRL: next_s.ctrl = {14'h0, pwdata[17:0]};
        `QCM_A_COUNT: next_s.count = pwdata;
        `QCM_A_HI: next_s.hi = pwdata; // RL2
        `QCM_A_LO: next_s.lo = pwdata; // RL2
        `QCM_A_START: next_s.start = pwdata; // RL5
        `QCM_A_CMP: next_s.cmp = pwdata;
        `QCM_A_HYST: next_s.hyst = pwdata;
        `QCM_A_UPD: next_s.upd = pwdata; // RL15
        default: next_s.hyst = next_s.hyst;
      endcase
    end
    // Hardware events are applied after software writes so that they win in a shared cycle.
    if (sif.step && gate)
    begin
      if (viol)
      begin
        if (s.ctrl.opp_reload)
          next_s.count = sif.up ? s.lo : s.hi; // RL4
        else
          next_s.count = s.start; // RL4 RL6
        if (s.ctrl.lim_stop)
          next_s.ctrl.sw_gate = 1'b0; // RL3
      end
      else
        next_s.count = sif.up ? s.count + 32'sh1 : s.count - 32'sh1; // RL1 RL23
    end
    if (gate_open && s.ctrl.gate_load)
      next_s.count = s.start; // RL6
    if (capt_ev)
    begin
      next_s.capt = s.count; // RL8
      if (s.ctrl.cap_load)
        next_s.count = s.start; // RL6 RL9
    end
    if (sync_ev)
      next_s.count = s.start; // RL6
    // Switch on at the compare value, off only below the hysteresis band.
    if (!s.cmp_out && s.count >= s.cmp)
      next_s.cmp_out = 1'b1; // RL11
    else if (s.cmp_out && s.count < s.cmp - $signed(s.hyst))
      next_s.cmp_out = 1'b0; // RL10
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.hi <= `QCM_HI_RST;
      s.lo <= `QCM_LO_RST;
      s.upd <= `QCM_UPD_RST;
    end
    else if (ce)
      s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////
  // Submodules.

  qcm_decoder u_dec (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .a(s.s2[0]),
    .b(s.s2[1]),
    .in_type(s.ctrl.in_type),
    .sif(sif.dec)
  );

  qcm_measure u_mea (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .mode(s.ctrl.mode),
    .upd_ticks(s.upd),
    .sif(sif.mea)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  assign plain = ce & sif.step & gate & ~gate_open & ~capt_ev & ~sync_ev & ~wr;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence qcm_up_step;
    plain && sif.up && !at_hi;
  endsequence
  sequence qcm_up_wrap;
    plain && sif.up && at_hi && s.ctrl.opp_reload;
  endsequence

  count_step_a: assert property (qcm_up_step |=> s.count == $past(s.count) + 32'sh1) // RL23
    else $error("count did not step up");
  limit_wrap_a: assert property (qcm_up_wrap |=> s.count == $past(s.lo)) // RL4
    else $error("count did not reload opposite limit");
  limit_stop_a: assert property (ce && viol && s.ctrl.lim_stop |=> !s.ctrl.sw_gate) // RL3
    else $error("gate not closed at limit");
  gate_hold_a: assert property (ce && !gate && !wr && !capt_ev && !sync_ev |=> $stable(s.count)) // RL7
    else $error("count moved with gate closed");
  capture_copy_a: assert property (ce && capt_ev |=> s.capt == $past(s.count)) // RL8
    else $error("capture missed count");
  sync_load_a: assert property (ce && sync_ev |=> s.count == $past(s.start)) // RL6
    else $error("sync did not load start value");
  cmp_on_a: assert property (ce && !s.cmp_out && s.count >= s.cmp |=> cmp_out) // RL11
    else $error("compare output did not switch on");
  hyst_hold_a: assert property (ce && s.cmp_out && s.count >= s.cmp - $signed(s.hyst) |=> cmp_out) // RL10
    else $error("compare output left inside hysteresis band");
endmodule

/* File: qcm_defs.svh */
`ifndef QCM_DEFS_SVH
`define QCM_DEFS_SVH
// Register byte offsets.
`define QCM_A_CTRL 8'h00
`define QCM_A_COUNT 8'h04
`define QCM_A_HI 8'h08
`define QCM_A_LO 8'h0C
`define QCM_A_START 8'h10
`define QCM_A_CAPT 8'h14
`define QCM_A_CMP 8'h18
`define QCM_A_HYST 8'h1C
`define QCM_A_UPD 8'h20
`define QCM_A_MEAS 8'h24
`define QCM_A_STAT 8'h28
// Reset values and conversion constants.
`define QCM_HI_RST 32'h7FFFFFFF
`define QCM_LO_RST 32'h80000000
`define QCM_ZERO 32'h00000000
`define QCM_CLK_MHZ 125
`define QCM_UPD_US 1000
`define QCM_UPD_RST (`QCM_UPD_US * `QCM_CLK_MHZ)
`define QCM_FLT_BIAS 8'h7F
`define QCM_MSB 5'h1F
`endif

/* File: qcm_pkg.sv */
package qcm_pkg;
  typedef enum logic [1:0] {QCM_QUAD = 2'b00, QCM_PDIR = 2'b01, QCM_PULSE = 2'b10, QCM_UPDN = 2'b11} qcm_in_t;
  typedef enum logic [1:0] {QCM_FN_NONE = 2'b00, QCM_FN_GATE = 2'b01, QCM_FN_CAPT = 2'b10, QCM_FN_SYNC = 2'b11} qcm_fn_t;
  typedef enum logic [1:0] {QCM_C_RISE = 2'b00, QCM_C_FALL = 2'b01, QCM_C_BOTH = 2'b10, QCM_C_ZERO = 2'b11} qcm_cap_t;
  typedef enum logic [1:0] {QCM_M_FREQ = 2'b00, QCM_M_PER = 2'b01, QCM_M_VEL = 2'b10, QCM_M_RSV = 2'b11} qcm_mode_t;
  typedef struct packed {
    logic [13:0] rsv;
    qcm_mode_t mode;
    qcm_cap_t cap_src;
    qcm_fn_t aux1_fn;
    qcm_fn_t aux0_fn;
    qcm_in_t in_type;
    logic sw_dir;
    logic sw_dir_en;
    logic cap_load;
    logic gate_load;
    logic opp_reload;
    logic lim_stop;
    logic hw_gate_en;
    logic sw_gate;
  } qcm_ctrl_t;
endpackage

/* File: qcm_step_if.sv */
interface qcm_step_if;
  logic step;
  logic enc_up;
  logic up;
  logic gate;
  logic [31:0] meas;
  modport dec (output step, output enc_up);
  modport cnt (input step, input enc_up, input meas, output up, output gate);
  modport mea (input step, input up, input gate, output meas);
endinterface

/* File: qcm_decoder.sv */
module qcm_decoder (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Synchronised tracks.
  input wire logic a,
  input wire logic b,
  input wire qcm_pkg::qcm_in_t in_type,
  // Step output.
  qcm_step_if.dec sif
);
  typedef struct packed {
    logic pa;
    logic pb;
    logic step;
    logic up;
  } qcm_dec_t;
  qcm_dec_t s;
  qcm_dec_t next_s;
  logic ea;
  logic eb;

  assign ea = a ^ s.pa;
  assign eb = b ^ s.pb;
  assign sif.step = s.step;
  assign sif.enc_up = s.up;

  always_comb
  begin
    next_s = s;
    next_s.pa = a;
    next_s.pb = b;
    next_s.step = 1'b0;
    unique case (in_type)
      qcm_pkg::QCM_QUAD:
      begin
        // Both tracks moving at once is an illegal transition and counts nothing.
        next_s.step = ea ^ eb; // RL23
        next_s.up = ea ? (a ^ s.pb) : ~(b ^ s.pa); // RL23
      end
      qcm_pkg::QCM_PDIR:
      begin
        next_s.step = ea & a; // RL20
        next_s.up = ~b;
      end
      qcm_pkg::QCM_PULSE:
      begin
        next_s.step = ea & a; // RL20
        next_s.up = 1'b1;
      end
      qcm_pkg::QCM_UPDN:
      begin
        next_s.step = (ea & a) ^ (eb & b); // RL20
        next_s.up = ea & a;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else if (ce)
      s <= next_s;
  end
endmodule

/* File: qcm_measure.sv */
`include "qcm_defs.svh"
module qcm_measure (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Configuration.
  input wire qcm_pkg::qcm_mode_t mode,
  input wire logic [31:0] upd_ticks,
  // Step stream and result.
  qcm_step_if.mea sif
);
  typedef struct packed {
    logic [31:0] tick;
    logic signed [31:0] delta;
    logic [31:0] per;
    logic signed [31:0] last_per;
    logic [31:0] meas;
  } qcm_mea_t;
  qcm_mea_t s;
  qcm_mea_t next_s;
  logic done;

  // Truncating signed integer to single-precision conversion.
  function automatic logic [31:0] qcm_flt(input logic signed [31:0] v);
    logic [31:0] m;
    logic [31:0] t;
    logic [4:0] e;
    m = v[31] ? 32'(-v) : 32'(v);
    e = 5'h00;
    for (int i = 0; i < 32; i++)
      if (m[i])
        e = 5'(i);
    t = m << (`QCM_MSB - e);
    qcm_flt = (m == `QCM_ZERO) ? `QCM_ZERO : {v[31], 8'(e) + `QCM_FLT_BIAS, t[30:8]};
  endfunction

  assign sif.meas = s.meas;
  assign done = s.tick + 32'h1 >= upd_ticks;

  always_comb
  begin
    next_s = s;
    // The interval runs free and is never restarted by the gate.
    next_s.tick = done ? `QCM_ZERO : s.tick + 32'h1; // RL16
    // Saturating keeps a very slow input reading as the longest period rather than wrapping.
    if (s.per != 32'hFFFFFFFF)
      next_s.per = s.per + 32'h1; // RL18
    if (sif.step && sif.gate)
    begin
      next_s.delta = sif.up ? s.delta + 32'sh1 : s.delta - 32'sh1; // RL19
      next_s.last_per = sif.up ? $signed(s.per) : -$signed(s.per); // RL19
      // Restarting at one makes the held value the full spacing between two steps.
      next_s.per = 32'h1;
    end
    if (done)
    begin
      // A step in the closing cycle opens the next interval, so no step is lost.
      next_s.delta = (sif.step && sif.gate) ? (sif.up ? 32'sh1 : -32'sh1) : 32'sh0; // RL15
      // A closed gate leaves the last result in place.
      if (sif.gate)
        next_s.meas = qcm_flt((mode == qcm_pkg::QCM_M_PER) ? s.last_per : s.delta); // RL12 RL13 RL17
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else if (ce)
      s <= next_s;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  meas_keep_a: assert property (ce && !sif.gate |=> $stable(s.meas)) // RL17
    else $error("measured value changed while gate closed");
endmodule

/* File: qcm_enc_model.sv */
module qcm_enc_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Step requests.
  input wire logic req,
  input wire logic run,
  input wire logic up,
  input wire qcm_pkg::qcm_in_t kind,
  // Encoder tracks.
  output logic enc_a,
  output logic enc_b
);
  logic [1:0] ph;
  logic [2:0] t;
  logic pul;
  ////////////////////////////////////////////////////////////////////////////////
  // A step spans eight clocks, so each level outlives the input synchroniser.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph <= 2'h0;
      t <= 3'h0;
      pul <= 1'h0;
    end
    else if (t != 3'h0 || req || run)
    begin
      t <= t + 3'h1;
      if (t == 3'h0)
      begin
        ph <= up ? ph + 2'h1 : ph - 2'h1;
        pul <= 1'h1;
      end
      else if (t == 3'h3)
        pul <= 1'h0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // A track that the mode ignores keeps moving, so a decoder that reads it is caught.
  always_comb
  begin
    case (kind)
      qcm_pkg::QCM_QUAD:
      begin
        enc_a = ph[0] ^ ph[1];
        enc_b = ph[1];
      end
      qcm_pkg::QCM_PDIR:
      begin
        enc_a = pul;
        enc_b = ~up;
      end
      qcm_pkg::QCM_PULSE:
      begin
        enc_a = pul;
        enc_b = t[0];
      end
      default:
      begin
        enc_a = pul & up;
        enc_b = pul & ~up;
      end
    endcase
  end
endmodule

/* File: tb.sv */
`include "qcm_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic enc_a;
  logic enc_b;
  logic enc_n = 1'h0;
  logic [1:0] aux = 2'h0;
  logic cmp_out;
  logic req = 1'h0;
  logic run = 1'h0;
  logic up = 1'h1;
  qcm_pkg::qcm_in_t kind = qcm_pkg::QCM_QUAD;
  int miscompares = 0;
  int n_checks = 0;
  logic [31:0] q;
  logic e;
  always #4 pclk = ~pclk;
  qcm_counter u_qcm_counter (.pclk(pclk), .presetn(presetn), .ce(1'h1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n), .counter_aux_input(aux), .cmp_out(cmp_out));
  qcm_enc_model u_qcm_enc_model (.pclk(pclk), .presetn(presetn), .req(req), .run(run), .up(up),
    .kind(kind), .enc_a(enc_a), .enc_b(enc_b));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (miscompares == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One idle cycle follows each transfer, so no request is raised in the edge that drops it.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20)
    begin
      chk("pready", 32'h0, 32'h1);
      finish_test();
    end
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk($sformatf("reg %h", a), q, exp);
  endtask
  task automatic stp(input logic dir, input int n);
    repeat (n)
    begin
      up <= dir;
      cyc(1);
      req <= 1'h1;
      @(posedge pclk);
      req <= 1'h0;
      cyc(9);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(`QCM_A_UPD, 32'h0001E848);
    wr(`QCM_A_UPD, 32'h40);
    rd(`QCM_A_CTRL, 32'h0);
    rd(`QCM_A_COUNT, 32'h0);
    rd(`QCM_A_HI, 32'h7FFFFFFF);
    rd(`QCM_A_LO, 32'h80000000);
    rd(`QCM_A_MEAS, 32'h0);
  endtask
  task automatic t_apb();
    apb(1'h0, 8'h2C, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    wr(`QCM_A_CTRL, 32'hFFFC0000);
    rd(`QCM_A_CTRL, 32'h0);
    wr(`QCM_A_CAPT, 32'h5);
    rd(`QCM_A_CAPT, 32'h0);
  endtask
  task automatic t_gate();
    stp(1'h1, 2);
    rd(`QCM_A_COUNT, 32'h0);
    wr(`QCM_A_CTRL, 32'h1);
    stp(1'h1, 5);
    rd(`QCM_A_COUNT, 32'h5);
    stp(1'h0, 2);
    rd(`QCM_A_COUNT, 32'h3);
    wr(`QCM_A_CTRL, 32'h41);
    stp(1'h1, 2);
    rd(`QCM_A_COUNT, 32'h1);
  endtask
  task automatic t_modes();
    logic [31:0] exp [4] = '{32'h0, 32'h1, 32'h3, 32'h1};
    for (int k = 1; k < 4; k++)
    begin
      wr(`QCM_A_CTRL, 32'(k) << 8);
      kind <= qcm_pkg::qcm_in_t'(k[1:0]);
      cyc(4);
      wr(`QCM_A_COUNT, 32'h0);
      wr(`QCM_A_CTRL, (32'(k) << 8) | 32'h1);
      stp(1'h1, 2);
      stp(1'h0, 1);
      rd(`QCM_A_COUNT, exp[k]);
    end
    wr(`QCM_A_CTRL, 32'h0);
    kind <= qcm_pkg::QCM_QUAD;
  endtask
  task automatic t_limits();
    wr(`QCM_A_HI, 32'h5);
    wr(`QCM_A_LO, 32'hFFFFFFFD);
    wr(`QCM_A_START, 32'h1);
    wr(`QCM_A_COUNT, 32'h4);
    wr(`QCM_A_CTRL, 32'h1);
    stp(1'h1, 1);
    rd(`QCM_A_COUNT, 32'h5);
    stp(1'h1, 1);
    rd(`QCM_A_COUNT, 32'h1);
    wr(`QCM_A_CTRL, 32'h9);
    wr(`QCM_A_COUNT, 32'h5);
    stp(1'h1, 1);
    rd(`QCM_A_COUNT, 32'hFFFFFFFD);
    stp(1'h0, 1);
    rd(`QCM_A_COUNT, 32'h5);
    wr(`QCM_A_CTRL, 32'hD);
    stp(1'h1, 2);
    rd(`QCM_A_CTRL, 32'hC);
    rd(`QCM_A_COUNT, 32'hFFFFFFFD);
    wr(`QCM_A_HI, 32'h7FFFFFFF);
    wr(`QCM_A_LO, 32'h80000000);
    wr(`QCM_A_COUNT, 32'h7FFFFFFE);
    wr(`QCM_A_CTRL, 32'h1);
    stp(1'h1, 1);
    rd(`QCM_A_COUNT, 32'h7FFFFFFF);
  endtask
  task automatic t_cmp();
    wr(`QCM_A_CTRL, 32'h0);
    wr(`QCM_A_CMP, 32'h3);
    wr(`QCM_A_HYST, 32'h1);
    wr(`QCM_A_COUNT, 32'h0);
    wr(`QCM_A_CTRL, 32'h1);
    chk("cmp_out", {31'h0, cmp_out}, 32'h0);
    stp(1'h1, 3);
    chk("cmp_out", {31'h0, cmp_out}, 32'h1);
    stp(1'h0, 1);
    chk("cmp_out", {31'h0, cmp_out}, 32'h1);
    stp(1'h0, 1);
    chk("cmp_out", {31'h0, cmp_out}, 32'h0);
  endtask
  task automatic t_capture();
    for (int s = 0; s < 4; s++)
    begin
      wr(`QCM_A_CTRL, 32'h800 | (32'(s) << 14));
      wr(`QCM_A_COUNT, 32'(16 * s + 1));
      if (s < 3)
        aux[0] <= 1'h1;
      else
        enc_n <= 1'h1;
      cyc(6);
      wr(`QCM_A_COUNT, 32'(16 * s + 2));
      aux[0] <= 1'h0;
      enc_n <= 1'h0;
      cyc(6);
      rd(`QCM_A_CAPT, 32'(16 * s + ((s == 0 || s == 3) ? 1 : 2)));
    end
    wr(`QCM_A_START, 32'h7);
    wr(`QCM_A_CTRL, 32'h820);
    wr(`QCM_A_COUNT, 32'h2);
    aux[0] <= 1'h1;
    cyc(6);
    rd(`QCM_A_COUNT, 32'h7);
    rd(`QCM_A_CAPT, 32'h2);
    aux[0] <= 1'h0;
  endtask
  task automatic t_hwgate();
    wr(`QCM_A_START, 32'h14);
    wr(`QCM_A_COUNT, 32'h0);
    wr(`QCM_A_CTRL, 32'h1013);
    stp(1'h1, 1);
    rd(`QCM_A_COUNT, 32'h0);
    aux[1] <= 1'h1;
    cyc(6);
    rd(`QCM_A_COUNT, 32'h14);
    stp(1'h1, 1);
    rd(`QCM_A_COUNT, 32'h15);
    aux[1] <= 1'h0;
  endtask
  // Steps every eight clocks against a 64-clock interval give exactly eight per interval.
  task automatic t_meas();
    for (int m = 0; m < 3; m++)
      for (int d = 0; d < 2; d++)
      begin
        wr(`QCM_A_CTRL, 32'h1 | (32'(m) << 16));
        up <= d[0];
        run <= 1'h1;
        cyc(200);
        rd(`QCM_A_MEAS, d ? 32'h41000000 : 32'hC1000000);
      end
    wr(`QCM_A_CTRL, 32'h20000);
    cyc(150);
    rd(`QCM_A_MEAS, 32'h41000000);
    run <= 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(10);
    presetn <= 1'h1;
    cyc(1);
    t_reset();
    t_apb();
    t_gate();
    t_modes();
    t_limits();
    t_cmp();
    t_capture();
    t_hwgate();
    t_meas();
    finish_test();
  end
endmodule
